// >>> rtl/pead_pkg.sv
// Constants, field layout and carrier types for the entry attribute decoder.
// Assumes a single clock domain and a plain register port.
package pead_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] REG_ENTRY = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CAPS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TAG = 8'h0C;

    // Entry attribute slice, bits 89 down to 64 of the table entry
    localparam int ATTR_LSB = 64;
    localparam int ATTR_W = 26;
    localparam int CD_POS = 89 - ATTR_LSB;
    localparam int REQUEST_FORCE_SNOOP_POS = 88 - ATTR_LSB;
    localparam int WALK_SNOOP_ENABLE_POS = 87 - ATTR_LSB;
    localparam int RSV_HI = 86 - ATTR_LSB;
    localparam int RSV_LO = 80 - ATTR_LSB;
    localparam int TAG_HI = 79 - ATTR_LSB;
    localparam int TAG_LO = 64 - ATTR_LSB;
    localparam int TAG_W = 16;
    localparam int NARROW_TAG_W = 8;
    localparam logic [ATTR_W-1:0] ENTRY_RST = 26'h0000000;

    // Capability register bits
    localparam int CAP_W = 5;
    localparam int CAP_MT = 0;
    localparam int CAP_SC = 1;
    localparam int CAP_PWC = 2;
    localparam int CAP_CM = 3;
    localparam int CAP_NARROW = 4;
    localparam logic [CAP_W-1:0] CAPS_RST = 5'h07;

    // Status register bits
    localparam int STS_W = 10;
    localparam int STS_CD = 0;
    localparam int STS_FSNP = 1;
    localparam int STS_WSNP = 2;
    localparam int STS_FAULT = 3;
    localparam int STS_CAUSE_LO = 4;

    // Fault cause bits
    localparam int CAUSE_W = 6;
    localparam int C_CD = 0;
    localparam int C_SNP = 1;
    localparam int C_WALK = 2;
    localparam int C_LOW = 3;
    localparam int C_TAGHI = 4;
    localparam int C_TAG0 = 5;

    // Memory types
    localparam int MT_W = 3;
    localparam logic [MT_W-1:0] MT_UC = 3'h0;

    typedef struct packed {
        logic cacheInhibit;
        logic forceSnoop;
        logic walkSnoop;
        logic [TAG_W-1:0] domainTag;
        logic [CAUSE_W-1:0] faultCause;
    } pead_decode_t;

    typedef struct packed {
        logic coherent;
        logic walkRead;
        logic snoopHint;
        logic [MT_W-1:0] memType;
    } pead_req_t;

    typedef struct packed {
        logic [MT_W-1:0] memType;
        logic snoop;
        logic [TAG_W-1:0] tag;
        logic fault;
    } pead_rsp_t;

    localparam pead_rsp_t RSP_RST = '{memType: MT_UC, snoop: 1'b0,
        tag: 16'h0000, fault: 1'b0};

endpackage

// >>> rtl/pead_field_decode.sv
// Combinational decode of the entry attribute slice against capabilities.
// Assumes its inputs are stable registers of the same clock domain.
`timescale 1ns/1ps
module pead_field_decode
    import pead_pkg::*;
(
    input wire logic [ATTR_W-1:0] attr,
    input wire logic [CAP_W-1:0] caps,
    output pead_decode_t dec
);

    logic [TAG_W-1:0] tagMask;

    // Per-bit tag mask; upper half unused in narrow mode
    genvar gi;
    generate
        for (gi = 0; gi < TAG_W; gi++) begin : g_mask
            assign tagMask[gi] = (gi < NARROW_TAG_W) || !caps[CAP_NARROW];
        end
    endgenerate

    always_comb begin
        dec = '0;
        dec.cacheInhibit = attr[CD_POS];
        dec.forceSnoop = attr[REQUEST_FORCE_SNOOP_POS];
        dec.walkSnoop = attr[WALK_SNOOP_ENABLE_POS];
        dec.domainTag = attr[TAG_HI:TAG_LO] & tagMask;
        // Bits set without support are reserved-zero violations
        dec.faultCause[C_CD] = attr[CD_POS] && !caps[CAP_MT];
        dec.faultCause[C_SNP] = attr[REQUEST_FORCE_SNOOP_POS] && !caps[CAP_SC];
        dec.faultCause[C_WALK] = attr[WALK_SNOOP_ENABLE_POS] && !caps[CAP_PWC];
        dec.faultCause[C_LOW] = |attr[RSV_HI:RSV_LO];
        dec.faultCause[C_TAGHI] = |(attr[TAG_HI:TAG_LO] & ~tagMask);
        dec.faultCause[C_TAG0] = caps[CAP_CM] && (dec.domainTag == '0);
    end

endmodule

// >>> rtl/pead_attr_unit.sv
// Entry attribute unit: register port, decode and request qualification.
// Assumes requests and register strobes come from logic on mclk.
`timescale 1ns/1ps
import pead_pkg::*;

// Operation
// - Cache-inhibit bit is reserved-zero without memory-type support.
// - Cache-inhibit acts only on coherent-domain requests.
// - Inhibit clear: the request memory type passes unchanged.
// - Inhibit set: effective memory type of coherent non-walk requests forced to uncacheable.
// - Cache keeps answering snoops while caching is inhibited.
// - Force-snoop bit is reserved-zero without snoop-control support.
// - Force-snoop set: non-walk requests always snoop; clear: the request snoop hint decides.
// - Walk-snoop bit is reserved-zero without walk-coherency support.
// - Walk-snoop decides whether paging-structure reads snoop.
// - Domain tag labels internal translation cache entries.
// - Unused upper tag bits reserved when tags are narrow.
module pead_attr_unit
    import pead_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input wire logic reqValid,
    input wire pead_req_t reqInfo,
    output logic rspValid,
    output pead_rsp_t rspInfo,
    output logic snoopRespond
);

    logic [ATTR_W-1:0] entryAttr_r;
    logic [ATTR_W-1:0] entryAttr_nxt;
    logic [CAP_W-1:0] caps_r;
    logic [CAP_W-1:0] caps_nxt;
    logic [DATA_W-1:0] rdData_r;
    logic [DATA_W-1:0] rdData_nxt;
    logic rspValid_r;
    logic rspValid_nxt;
    pead_rsp_t rsp_r;
    pead_rsp_t rsp_nxt;
    logic snoopRespond_r;
    logic snoopRespond_nxt;
    pead_decode_t dec;
    logic entryFault;
    logic [STS_W-1:0] status;

    pead_field_decode u_decode (
        .attr(entryAttr_r),
        .caps(caps_r),
        .dec(dec)
    );

    assign entryFault = |dec.faultCause;

    always_comb begin
        status = '0;
        status[STS_CD] = dec.cacheInhibit;
        status[STS_FSNP] = dec.forceSnoop;
        status[STS_WSNP] = dec.walkSnoop;
        status[STS_FAULT] = entryFault;
        status[STS_CAUSE_LO +: CAUSE_W] = dec.faultCause;
    end

    // Register port
    always_comb begin
        entryAttr_nxt = entryAttr_r;
        caps_nxt = caps_r;
        rdData_nxt = '0;
        if (regWr) begin
            case (regAddr)
                REG_ENTRY: entryAttr_nxt = regWrData[ATTR_W-1:0];
                REG_CAPS: caps_nxt = regWrData[CAP_W-1:0];
                default: ;
            endcase
        end
        // Data stands one cycle only; unmapped reads give zero
        if (regRd) begin
            case (regAddr)
                REG_ENTRY: rdData_nxt = {{(DATA_W-ATTR_W){1'b0}}, entryAttr_r};
                REG_CAPS: rdData_nxt = {{(DATA_W-CAP_W){1'b0}}, caps_r};
                REG_STATUS: rdData_nxt = {{(DATA_W-STS_W){1'b0}}, status};
                REG_TAG: rdData_nxt = {{(DATA_W-TAG_W){1'b0}}, dec.domainTag};
                default: rdData_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            entryAttr_r <= ENTRY_RST;
            caps_r <= CAPS_RST;
            rdData_r <= '0;
        end else begin
            entryAttr_r <= entryAttr_nxt;
            caps_r <= caps_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    // Request qualification, answered one cycle after the request
    always_comb begin
        rspValid_nxt = reqValid;
        rsp_nxt = RSP_RST;
        snoopRespond_nxt = 1'b1;
        if (reqValid) begin
            rsp_nxt.tag = dec.domainTag;
            rsp_nxt.memType = reqInfo.memType;
            if (reqInfo.walkRead) begin
                rsp_nxt.snoop = dec.walkSnoop;
            end else begin
                rsp_nxt.snoop = dec.forceSnoop || reqInfo.snoopHint;
                if (dec.cacheInhibit && reqInfo.coherent) begin
                    rsp_nxt.memType = MT_UC;
                end
            end
            // A malformed entry yields no tag, no snoop and uncacheable
            if (entryFault) begin
                rsp_nxt.fault = 1'b1;
                rsp_nxt.snoop = 1'b0;
                rsp_nxt.memType = MT_UC;
                rsp_nxt.tag = '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rspValid_r <= 1'b0;
            rsp_r <= RSP_RST;
            snoopRespond_r <= 1'b1;
        end else begin
            rspValid_r <= rspValid_nxt;
            rsp_r <= rsp_nxt;
            snoopRespond_r <= snoopRespond_nxt;
        end
    end

    assign rspValid = rspValid_r;
    assign rspInfo = rsp_r;
    assign snoopRespond = snoopRespond_r;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    cd_reserved_a: assert property (
        reqValid && !caps_r[CAP_MT] && entryAttr_r[CD_POS]
        |=> rspValid && rspInfo.fault)
        else $error("Inhibit bit without memory-type support not faulted");

    cd_scope_a: assert property (
        reqValid && !reqInfo.coherent && !reqInfo.walkRead && !entryFault
        |=> rspInfo.memType == $past(reqInfo.memType))
        else $error("Inhibit applied to non-coherent request");

    normal_cache_a: assert property (
        reqValid && !dec.cacheInhibit && !entryFault
        |=> rspInfo.memType == $past(reqInfo.memType))
        else $error("Memory type altered with inhibit clear");

    force_uc_a: assert property (
        reqValid && reqInfo.coherent && !reqInfo.walkRead
        && dec.cacheInhibit && !entryFault
        |=> rspValid && rspInfo.memType == MT_UC)
        else $error("Inhibited coherent request not uncacheable");

    snoop_answer_a: assert property (
        dec.cacheInhibit |-> snoopRespond ##1 snoopRespond)
        else $error("Snoop answering dropped while inhibited");

    snp_reserved_a: assert property (
        reqValid && !caps_r[CAP_SC] && entryAttr_r[REQUEST_FORCE_SNOOP_POS]
        |=> rspInfo.fault && !rspInfo.snoop)
        else $error("Force-snoop without support not faulted");

    force_snoop_a: assert property (
        reqValid && !reqInfo.walkRead && !entryFault
        |=> rspInfo.snoop == ($past(dec.forceSnoop)
            || $past(reqInfo.snoopHint)))
        else $error("Request snoop decision wrong");

    walk_reserved_a: assert property (
        reqValid && !caps_r[CAP_PWC] && entryAttr_r[WALK_SNOOP_ENABLE_POS]
        |=> rspInfo.fault)
        else $error("Walk-snoop without support not faulted");

    walk_snoop_a: assert property (
        reqValid && reqInfo.walkRead && !entryFault
        |=> rspInfo.snoop == $past(dec.walkSnoop))
        else $error("Walk read snoop does not follow entry");

    low_reserved_a: assert property (
        reqValid && (|entryAttr_r[RSV_HI:RSV_LO])
        |=> rspInfo.fault && rspInfo.tag == '0)
        else $error("Reserved low bits set but not faulted");

    tag_label_a: assert property (
        reqValid && !entryFault
        |=> rspValid && rspInfo.tag == $past(dec.domainTag))
        else $error("Response tag differs from entry tag");

    tag_narrow_a: assert property (
        caps_r[CAP_NARROW] |-> dec.domainTag[TAG_W-1:NARROW_TAG_W] == '0)
        else $error("Upper tag bits leak in narrow mode");

    zero_tag_a: assert property (
        reqValid && caps_r[CAP_CM] && dec.domainTag == '0
        |=> rspInfo.fault)
        else $error("Zero tag accepted in caching mode");

    read_once_a: assert property (
        !regRd |=> regRdData == '0)
        else $error("Read data outside its cycle");

endmodule

// >>> verification/pead_dma_model.sv
// DMA requester model standing in front of the attribute unit.
// Assumes start pulses come from the bench, one cycle each, on mclk.
`timescale 1ns/1ps
module pead_dma_model
    import pead_pkg::*;
(
    input wire logic mclk,
    input wire logic start,
    input wire pead_req_t startInfo,
    output logic reqValid,
    output pead_req_t reqInfo,
    input wire logic rspValid,
    input wire pead_rsp_t rspInfo,
    output logic done,
    output pead_rsp_t gotRsp
);
    initial begin
        reqValid = 1'b0;
        reqInfo = '0;
        done = 1'b0;
        gotRsp = '0;
    end
    always @(posedge mclk) begin
        reqValid <= start;
        // Idle qualifiers toggle so a stale value never passes as valid
        reqInfo <= start ? startInfo : ~reqInfo;
        done <= (rspValid === 1'b1);
        if (rspValid === 1'b1) begin
            gotRsp <= rspInfo;
        end
    end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the entry attribute unit.
// Assumes the package, the design and the DMA model are compiled first.
`timescale 1ns/1ps
module tb_top
    import pead_pkg::*;
();
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWrData = 32'h0;
    logic [DATA_W-1:0] regRdData;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic reqValid, rspValid, snoopRespond, done;
    logic start = 1'b0;
    pead_req_t reqInfo;
    pead_req_t startInfo = '0;
    pead_rsp_t rspInfo, gotRsp, r;
    logic [31:0] d;
    int errCount = 0;
    int cmpCount = 0;

    always #25 mclk = ~mclk;

    pead_attr_unit uut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .reqValid(reqValid), .reqInfo(reqInfo),
        .rspValid(rspValid), .rspInfo(rspInfo),
        .snoopRespond(snoopRespond));
    pead_dma_model dma (.mclk(mclk), .start(start), .startInfo(startInfo),
        .reqValid(reqValid), .reqInfo(reqInfo), .rspValid(rspValid),
        .rspInfo(rspInfo), .done(done), .gotRsp(gotRsp));

    task automatic closeOut();
        $display("compares %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chkD(string n, logic [31:0] e, logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            errCount++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chkR(string n, pead_rsp_t e, pead_rsp_t g);
        cmpCount++;
        if (g !== e) begin
            errCount++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    function automatic pead_rsp_t ex(logic [2:0] m, logic s, logic [15:0] t,
        logic f);
        return '{memType: m, snoop: s, tag: t, fault: f};
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        v = regRdData;
    endtask

    task automatic req(logic c, logic w, logic h, logic [2:0] m,
        output pead_rsp_t q);
        int i;
        @(posedge mclk);
        startInfo <= '{coherent: c, walkRead: w, snoopHint: h, memType: m};
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1) break;
        end
        if (i == 8) begin
            errCount++;
            $display("[FAIL] response wait exp 1 got 0");
            closeOut();
        end
        q = gotRsp;
    endtask

    task automatic tReset();
        rd(REG_CAPS, d);
        chkD("caps", 32'h00000007, d);
        rd(REG_ENTRY, d);
        chkD("entry", 32'h00000000, d);
        rd(8'h10, d);
        chkD("unmapped", 32'h00000000, d);
        chkD("snoopRespond", 32'h00000001, {31'h0, snoopRespond});
        $display("tReset done");
    endtask

    task automatic tInhibit();
        wr(REG_CAPS, 32'h00000007);
        wr(REG_ENTRY, 32'h02001234);
        req(1'b1, 1'b0, 1'b0, 3'h6, r);
        chkR("cd coherent", ex(MT_UC, 1'b0, 16'h1234, 1'b0), r);
        req(1'b0, 1'b0, 1'b0, 3'h6, r);
        chkR("cd other", ex(3'h6, 1'b0, 16'h1234, 1'b0), r);
        req(1'b1, 1'b1, 1'b0, 3'h6, r);
        chkR("cd walk", ex(3'h6, 1'b0, 16'h1234, 1'b0), r);
        chkD("snoopRespond", 32'h00000001, {31'h0, snoopRespond});
        wr(REG_ENTRY, 32'h00001234);
        req(1'b1, 1'b0, 1'b0, 3'h6, r);
        chkR("cd clear", ex(3'h6, 1'b0, 16'h1234, 1'b0), r);
        $display("tInhibit done");
    endtask

    task automatic tSnoop();
        wr(REG_ENTRY, 32'h01001234);
        req(1'b0, 1'b0, 1'b0, 3'h2, r);
        chkR("force", ex(3'h2, 1'b1, 16'h1234, 1'b0), r);
        // Walk reads follow only the walk bit, never the force bit
        req(1'b0, 1'b1, 1'b1, 3'h2, r);
        chkR("walk off", ex(3'h2, 1'b0, 16'h1234, 1'b0), r);
        wr(REG_ENTRY, 32'h00801234);
        req(1'b0, 1'b0, 1'b1, 3'h2, r);
        chkR("hint", ex(3'h2, 1'b1, 16'h1234, 1'b0), r);
        req(1'b0, 1'b0, 1'b0, 3'h2, r);
        chkR("no hint", ex(3'h2, 1'b0, 16'h1234, 1'b0), r);
        req(1'b0, 1'b1, 1'b0, 3'h2, r);
        chkR("walk on", ex(3'h2, 1'b1, 16'h1234, 1'b0), r);
        $display("tSnoop done");
    endtask

    task automatic tFault();
        logic [31:0] caps [6] = '{32'h06, 32'h05, 32'h03, 32'h07, 32'h17,
            32'h0F};
        logic [31:0] ent [6] = '{32'h02000001, 32'h01000001, 32'h00800001,
            32'h00010001, 32'h00000100, 32'h00000000};
        int cause [6] = '{C_CD, C_SNP, C_WALK, C_LOW, C_TAGHI, C_TAG0};
        for (int i = 0; i < 6; i++) begin
            wr(REG_CAPS, caps[i]);
            wr(REG_ENTRY, ent[i]);
            req(1'b1, 1'b0, 1'b1, 3'h5, r);
            chkR("fault rsp", ex(MT_UC, 1'b0, 16'h0000, 1'b1), r);
            rd(REG_STATUS, d);
            chkD("fault sts", 32'h1, {31'h0, d[STS_FAULT]});
            chkD("cause", 32'h1 << cause[i], {26'h0, d[9:4]});
        end
        $display("tFault done");
    endtask

    task automatic tTag();
        wr(REG_CAPS, 32'h00000007);
        wr(REG_ENTRY, 32'h0000BEEF);
        req(1'b0, 1'b0, 1'b0, 3'h1, r);
        chkR("tag", ex(3'h1, 1'b0, 16'hBEEF, 1'b0), r);
        rd(REG_TAG, d);
        chkD("tag reg", 32'h0000BEEF, d);
        wr(REG_CAPS, 32'h00000017);
        wr(REG_ENTRY, 32'h000000AB);
        wr(REG_TAG, 32'h00001111);
        req(1'b0, 1'b0, 1'b0, 3'h1, r);
        chkR("narrow", ex(3'h1, 1'b0, 16'h00AB, 1'b0), r);
        rd(REG_TAG, d);
        chkD("tag ro", 32'h000000AB, d);
        $display("tTag done");
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        tReset();
        tInhibit();
        tSnoop();
        tFault();
        tTag();
        closeOut();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errCount++;
        $display("[FAIL] run length exp 20000 got more");
        closeOut();
    end
endmodule
